// ==== src/hpfc_pkg.sv ====
// Shared constants and types for the haptic power and fire control block
package hpfc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_MODE      = 8'h01;
  localparam logic [7:0] ADDR_SEQ_FIRST = 8'h04;
  localparam logic [7:0] ADDR_SEQ_LAST  = 8'h0B;
  localparam logic [7:0] ADDR_FIRE      = 8'h0C;
  localparam logic [7:0] ADDR_RATED     = 8'h16;
  localparam logic [7:0] ADDR_PEAK      = 8'h17;
  localparam logic [7:0] ADDR_LOOP_CTRL = 8'h1D;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STATUS_OC_BIT   = 0;
  localparam int MODE_RESET_BIT  = 7;
  localparam int MODE_HOLD_BIT   = 6;
  localparam int MODE_SEL_LSB    = 0;
  localparam int FIRE_BIT_POS    = 0;
  localparam int LOOP_OPEN_BIT   = 0;
  localparam int SEQ_SLOTS       = 8;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RESET_VAL  = 8'h40;
  localparam logic [7:0] SEQ_RESET_VAL   = 8'h00;
  localparam logic [7:0] RATED_RESET_VAL = 8'h3F;
  localparam logic [7:0] PEAK_RESET_VAL  = 8'h89;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int SLOT_TIME_US    = 1000;
  localparam int PROC_TIME_US    = 1000;
  localparam int SLOT_CYCLES_DEF = (SLOT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int PROC_CYCLES_DEF = (PROC_TIME_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_SHUTDOWN = 2'b00,
    PWR_STANDBY  = 2'b01,
    PWR_READY    = 2'b11,
    PWR_ACTIVE   = 2'b10
  } hpfc_power_t;

  typedef enum logic [1:0] {
    PROC_IDLE = 2'b00,
    PROC_PLAY = 2'b01,
    PROC_CAL  = 2'b11,
    PROC_DIAG = 2'b10
  } hpfc_proc_t;

  typedef enum logic [2:0] {
    MODE_INT_TRIG   = 3'h0,
    MODE_EDGE_TRIG  = 3'h1,
    MODE_LEVEL_TRIG = 3'h2,
    MODE_PWM        = 3'h3,
    MODE_AUDIO      = 3'h4,
    MODE_REALTIME   = 3'h5,
    MODE_DIAG       = 3'h6,
    MODE_CAL        = 3'h7
  } hpfc_mode_t;

endpackage : hpfc_pkg

// ==== src/hpfc_power_fire.sv ====
// Power states, fire control and short handling of the haptic driver
// Function
// - Chip active pin high means active; low means shutdown, registers kept.
// - With chip active pin low, no register read or write is performed.
// - Low power hold bit forces standby and is set after reset.
// - Standby keeps registers and still serves reads and writes.
// - Setting low power hold stops any playing waveform at once.
// - Clearing low power hold moves standby to ready.
// - Full soft reset aborts playback and returns all registers to defaults.
// - Full soft reset bit clears itself after the reset finishes.
// - Fire signal in ready state starts playback, calibration or diagnostics.
// - Short seen in the first cycle of a process blocks further starts until the mode field changes.
// - Playback plays the waveform identifiers of sequencer slots 0x04 to 0x0B.
// - Fire bit stays set during the sequence and clears at its end.
// - Host clearing fire bit during playback cancels the sequence.
// - In external trigger modes the pin drives the fire bit.
// - Continuous modes assert fire signal without touching stored fire bit.
// - Output short during a process sets flag until gone and cuts current.
// - Shorts are checked only while a process runs.
// - Regulator short shuts down; on removal restart from defaults.
// - Open loop takes drive level from peak limit, ignoring steady level.
// - Edge mode: rising edge sets, second rising edge clears, falling ignored.
// - Level mode: fire bit follows the pin, a falling edge cancels.
`timescale 1ns/10ps
module hpfc_power_fire
  import hpfc_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEF,
  parameter int unsigned PROC_CYCLES = PROC_CYCLES_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       chip_active_pin,
  input  wire logic       external_trigger_pin,
  input  wire logic       regulator_short_pin,
  input  wire logic       output_short_sense,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  output logic      [1:0] power_state,
  output logic            fire_signal,
  output logic            drive_enable,
  output logic      [7:0] drive_level,
  output logic      [7:0] active_waveform,
  output logic            output_overcurrent_flag
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        regs_rst;
  logic        wr_ok;
  logic        rd_ok;
  logic        can_run;
  logic        cont_sel;
  logic        fire_sig;
  logic        ext_rise;
  logic        mode_changed;
  logic        proc_finish;
  logic        proc_start;
  logic [7:0]  rdata_next;
  hpfc_power_t power_next;
  hpfc_proc_t  proc_kind;
  logic        soft_rst_reg;
  logic        hold_reg;
  hpfc_mode_t  mode_sel_reg;
  logic [7:0]  seq_reg [SEQ_SLOTS];
  logic [7:0]  rated_reg;
  logic [7:0]  peak_reg;
  logic        open_loop_reg;
  logic        fire_bit_reg;
  logic        ext_prev_reg;
  logic        oc_flag_reg;
  logic        oc_lock_reg;
  logic        proc_first_reg;
  hpfc_proc_t  proc_reg;
  logic [2:0]  slot_reg;
  logic [31:0] cnt_reg;
  logic [7:0]  reg_rdata_reg;
  logic        reg_rd_valid_reg;
  hpfc_power_t power_reg;
  logic        fire_signal_reg;
  logic        drive_enable_reg;
  logic [7:0]  drive_level_reg;
  logic [7:0]  active_waveform_reg;
  // ----------------------------------------------------------------
  // Access gating and reset sources
  // ----------------------------------------------------------------
  assign regs_rst = sys_rst | soft_rst_reg | regulator_short_pin;
  assign wr_ok    = reg_wr_en & chip_active_pin & ~regulator_short_pin & ~soft_rst_reg;
  assign rd_ok    = reg_rd_en & chip_active_pin & ~regulator_short_pin;
  assign can_run  = chip_active_pin & ~hold_reg & ~regulator_short_pin;
  assign cont_sel = mode_sel_reg inside {MODE_PWM, MODE_AUDIO, MODE_REALTIME};
  assign fire_sig = fire_bit_reg | cont_sel;
  assign ext_rise = external_trigger_pin & ~ext_prev_reg;
  assign mode_changed = wr_ok && (reg_addr == ADDR_MODE) &&
                        (reg_wdata[MODE_SEL_LSB +: 3] != mode_sel_reg);
  // ----------------------------------------------------------------
  // Mode and power control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst || regulator_short_pin) begin
      soft_rst_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      soft_rst_reg <= 1'b0;
    end else if (wr_ok && reg_addr == ADDR_MODE) begin
      soft_rst_reg <= reg_wdata[MODE_RESET_BIT];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (regs_rst) begin
      hold_reg     <= MODE_RESET_VAL[MODE_HOLD_BIT];
      mode_sel_reg <= hpfc_mode_t'(MODE_RESET_VAL[MODE_SEL_LSB +: 3]);
    end else if (wr_ok && reg_addr == ADDR_MODE) begin
      hold_reg     <= reg_wdata[MODE_HOLD_BIT];
      mode_sel_reg <= hpfc_mode_t'(reg_wdata[MODE_SEL_LSB +: 3]);
    end
  end
  // ----------------------------------------------------------------
  // Sequencer, level and loop registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (regs_rst) begin
      for (int i = 0; i < SEQ_SLOTS; i++) begin
        seq_reg[i] <= SEQ_RESET_VAL;
      end
      rated_reg     <= RATED_RESET_VAL;
      peak_reg      <= PEAK_RESET_VAL;
      open_loop_reg <= 1'b0;
    end else if (wr_ok) begin
      if (reg_addr >= ADDR_SEQ_FIRST && reg_addr <= ADDR_SEQ_LAST) begin
        seq_reg[3'(reg_addr - ADDR_SEQ_FIRST)] <= reg_wdata;
      end else if (reg_addr == ADDR_RATED) begin
        rated_reg <= reg_wdata;
      end else if (reg_addr == ADDR_PEAK) begin
        peak_reg <= reg_wdata;
      end else if (reg_addr == ADDR_LOOP_CTRL) begin
        open_loop_reg <= reg_wdata[LOOP_OPEN_BIT];
      end
    end
  end
  // ----------------------------------------------------------------
  // Fire bit
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    ext_prev_reg <= sys_rst ? 1'b0 : external_trigger_pin;
  end
  always_ff @(posedge ref_clk) begin
    if (regs_rst) begin
      fire_bit_reg <= 1'b0;
    end else if (mode_sel_reg == MODE_LEVEL_TRIG) begin
      fire_bit_reg <= external_trigger_pin;
    end else if (wr_ok && reg_addr == ADDR_FIRE) begin
      fire_bit_reg <= reg_wdata[FIRE_BIT_POS];
    end else if (mode_sel_reg == MODE_EDGE_TRIG && ext_rise) begin
      fire_bit_reg <= ~fire_bit_reg;
    end else if (proc_finish || hold_reg) begin
      fire_bit_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Process engine
  // ----------------------------------------------------------------
  always_comb begin
    if (mode_sel_reg == MODE_CAL) begin
      proc_kind = PROC_CAL;
    end else if (mode_sel_reg == MODE_DIAG) begin
      proc_kind = PROC_DIAG;
    end else begin
      proc_kind = PROC_PLAY;
    end
  end
  assign proc_start = can_run && (proc_reg == PROC_IDLE) && fire_sig && !oc_lock_reg;
  always_comb begin
    proc_finish = 1'b0;
    if (can_run && proc_reg != PROC_IDLE && fire_sig) begin
      if (output_short_sense) begin
        proc_finish = 1'b1;
      end else if (proc_reg == PROC_PLAY) begin
        if (!cont_sel && (seq_reg[slot_reg] == SEQ_RESET_VAL ||
            (slot_reg == 3'(SEQ_SLOTS - 1) && cnt_reg == SLOT_CYCLES - 1))) begin
          proc_finish = 1'b1;
        end
      end else if (cnt_reg == PROC_CYCLES - 1) begin
        proc_finish = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (regs_rst || !can_run) begin
      proc_reg       <= PROC_IDLE;
      slot_reg       <= 3'h0;
      cnt_reg        <= 32'h0000_0000;
      proc_first_reg <= 1'b0;
    end else begin
      proc_first_reg <= proc_start;
      case (proc_reg)
        PROC_IDLE: begin
          if (proc_start) begin
            proc_reg <= proc_kind;
            slot_reg <= 3'h0;
            cnt_reg  <= 32'h0000_0000;
          end
        end
        default: begin
          if (!fire_sig || proc_finish) begin
            proc_reg <= PROC_IDLE;
          end else if (proc_reg == PROC_PLAY && cont_sel) begin
            cnt_reg <= 32'h0000_0000;
          end else if (proc_reg == PROC_PLAY && cnt_reg == SLOT_CYCLES - 1) begin
            cnt_reg  <= 32'h0000_0000;
            slot_reg <= slot_reg + 3'h1;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Output short handling
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (regs_rst) begin
      oc_flag_reg <= 1'b0;
    end else if (proc_reg != PROC_IDLE && output_short_sense) begin
      oc_flag_reg <= 1'b1;
    end else if (!output_short_sense) begin
      oc_flag_reg <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (regs_rst) begin
      oc_lock_reg <= 1'b0;
    end else if (proc_first_reg && output_short_sense) begin
      oc_lock_reg <= 1'b1;
    end else if (mode_changed) begin
      oc_lock_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_comb begin
    if (!chip_active_pin || regulator_short_pin) begin
      power_next = PWR_SHUTDOWN;
    end else if (hold_reg) begin
      power_next = PWR_STANDBY;
    end else if (proc_reg != PROC_IDLE) begin
      power_next = PWR_ACTIVE;
    end else begin
      power_next = PWR_READY;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      power_reg <= PWR_STANDBY;
    end else begin
      power_reg <= power_next;
    end
  end
  // ----------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fire_signal_reg     <= 1'b0;
      drive_enable_reg    <= 1'b0;
      drive_level_reg     <= 8'h00;
      active_waveform_reg <= 8'h00;
    end else begin
      fire_signal_reg     <= fire_sig & ~regs_rst;
      drive_enable_reg    <= (proc_reg != PROC_IDLE) & can_run & ~output_short_sense;
      drive_level_reg     <= open_loop_reg ? peak_reg : rated_reg;
      active_waveform_reg <= (proc_reg == PROC_PLAY && !cont_sel) ? seq_reg[slot_reg] : 8'h00;
    end
  end
  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == ADDR_STATUS) begin
      rdata_next[STATUS_OC_BIT] = oc_flag_reg;
    end else if (reg_addr == ADDR_MODE) begin
      rdata_next[MODE_RESET_BIT]      = soft_rst_reg;
      rdata_next[MODE_HOLD_BIT]       = hold_reg;
      rdata_next[MODE_SEL_LSB +: 3]   = mode_sel_reg;
    end else if (reg_addr >= ADDR_SEQ_FIRST && reg_addr <= ADDR_SEQ_LAST) begin
      rdata_next = seq_reg[3'(reg_addr - ADDR_SEQ_FIRST)];
    end else if (reg_addr == ADDR_FIRE) begin
      rdata_next[FIRE_BIT_POS] = fire_bit_reg;
    end else if (reg_addr == ADDR_RATED) begin
      rdata_next = rated_reg;
    end else if (reg_addr == ADDR_PEAK) begin
      rdata_next = peak_reg;
    end else if (reg_addr == ADDR_LOOP_CTRL) begin
      rdata_next[LOOP_OPEN_BIT] = open_loop_reg;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata_reg    <= 8'h00;
      reg_rd_valid_reg <= 1'b0;
    end else begin
      reg_rd_valid_reg <= rd_ok;
      if (rd_ok) begin
        reg_rdata_reg <= rdata_next;
      end
    end
  end
  assign reg_rdata               = reg_rdata_reg;
  assign reg_rd_valid            = reg_rd_valid_reg;
  assign power_state             = power_reg;
  assign fire_signal             = fire_signal_reg;
  assign drive_enable            = drive_enable_reg;
  assign drive_level             = drive_level_reg;
  assign active_waveform         = active_waveform_reg;
  assign output_overcurrent_flag = oc_flag_reg;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_pin_low_shutdown: assert property (!chip_active_pin |=> power_state == PWR_SHUTDOWN)
    else $error("Chip inactive but not shut down");
  chk_no_read_inactive: assert property (!chip_active_pin |=> !reg_rd_valid)
    else $error("Read served while chip inactive");
  chk_hold_standby: assert property (chip_active_pin && !regulator_short_pin && hold_reg
                                     |=> power_state == PWR_STANDBY)
    else $error("Hold set but not in standby");
  chk_hold_stops_play: assert property (hold_reg |=> proc_reg == PROC_IDLE ##1 !drive_enable)
    else $error("Playback continued under hold");
  chk_soft_rst_clear: assert property ($rose(soft_rst_reg) |=> !soft_rst_reg && hold_reg
                                       && !fire_bit_reg)
    else $error("Soft reset did not restore defaults or self-clear");
  chk_fire_cancel: assert property (proc_reg == PROC_PLAY && !fire_sig && can_run
                                    |=> proc_reg == PROC_IDLE)
    else $error("Cleared fire did not cancel playback");
  chk_level_follow: assert property (mode_sel_reg == MODE_LEVEL_TRIG && !regs_rst
                                     && $stable(mode_sel_reg)
                                     |=> fire_bit_reg == $past(external_trigger_pin))
    else $error("Fire bit does not follow trigger level");
  chk_cont_no_store: assert property (cont_sel && !fire_bit_reg && !wr_ok && !regs_rst
                                      && $stable(mode_sel_reg) |=> !fire_bit_reg)
    else $error("Continuous mode altered stored fire bit");
  chk_oc_idle_quiet: assert property (proc_reg == PROC_IDLE && !oc_flag_reg
                                      |=> !oc_flag_reg)
    else $error("Short flagged while idle");
  chk_oc_lock_blocks: assert property (oc_lock_reg && !mode_changed && !regs_rst
                                       |=> proc_reg == PROC_IDLE)
    else $error("Playback started while short lock held");
  chk_open_loop_level: assert property (open_loop_reg ##1 $stable(peak_reg)
                                        |-> drive_level == peak_reg)
    else $error("Open loop level not from peak limit");
  cov_play_done: cover property (proc_reg == PROC_PLAY ##1 proc_reg == PROC_IDLE && !fire_bit_reg);
  cov_edge_cancel: cover property (mode_sel_reg == MODE_EDGE_TRIG && fire_bit_reg && ext_rise);
  cov_oc_lock: cover property ($rose(oc_lock_reg));
endmodule : hpfc_power_fire

// ==== testbench/hpfc_host_model.sv ====
// Host model driving the register strobes and the control pins
`timescale 1ns/10ps
module hpfc_host_model (
  input  wire logic       ref_clk,
  output logic            chip_active_pin,
  output logic            external_trigger_pin,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    chip_active_pin      = 1'b1;
    external_trigger_pin = 1'b0;
    reg_wr_en            = 1'b0;
    reg_rd_en            = 1'b0;
    reg_addr             = 8'h00;
    reg_wdata            = 8'h00;
  end
  // Strobe stands one edge, released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
  endtask : rd
  task automatic pins(input logic en, input logic tg);
    @(posedge ref_clk);
    chip_active_pin      <= en;
    external_trigger_pin <= tg;
  endtask : pins
endmodule : hpfc_host_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the haptic power and fire control block
`timescale 1ns/10ps
module tb_top import hpfc_pkg::*; ;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       regulator_short_pin = 1'b0;
  logic       output_short_sense = 1'b0;
  logic       chip_active_pin, external_trigger_pin, reg_wr_en, reg_rd_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_level, active_waveform;
  logic [1:0] power_state;
  logic       reg_rd_valid, fire_signal, drive_enable, output_overcurrent_flag;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  int         err_count = 0;
  int         checks = 0;

  always #20 ref_clk = ~ref_clk;

  hpfc_host_model u_host (.ref_clk(ref_clk), .chip_active_pin(chip_active_pin),
    .external_trigger_pin(external_trigger_pin), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  hpfc_power_fire #(.SLOT_CYCLES(8), .PROC_CYCLES(8)) u_dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .chip_active_pin(chip_active_pin),
    .external_trigger_pin(external_trigger_pin), .regulator_short_pin(regulator_short_pin),
    .output_short_sense(output_short_sense), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .power_state(power_state), .fire_signal(fire_signal),
    .drive_enable(drive_enable), .drive_level(drive_level),
    .active_waveform(active_waveform), .output_overcurrent_flag(output_overcurrent_flag));

  task automatic test_done();
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic chk_rd(input logic [7:0] e);
    chk("reg_rdata", e, reg_rdata);
  endtask : chk_rd

  // ------------------------------------------------------------
  // Read answer monitor
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("reg_rd_valid", 8'h00, 8'h01);
      else chk_rd(exp_q.pop_front());
    end
  end

  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : w

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask : rd

  task automatic idle();
    repeat (60) if (fire_signal !== 1'b0) @(posedge ref_clk);
    #1;
    chk("fire_signal", 8'h00, fire_signal);
  endtask : idle

  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    test_done();
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h0000_a252));
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    w(1);
    chk("power_state", PWR_STANDBY, power_state);
    rd(ADDR_MODE, MODE_RESET_VAL);
    rd(ADDR_RATED, RATED_RESET_VAL);
    rd(ADDR_PEAK, PEAK_RESET_VAL);
    rd(8'h30, 8'h00);
    r = 8'($urandom_range(1, 255));
    u_host.wr(ADDR_SEQ_FIRST, r);
    u_host.wr(ADDR_SEQ_FIRST + 8'h01, 8'h27);
    rd(ADDR_SEQ_FIRST, r);
    u_host.wr(ADDR_MODE, 8'h00);
    w(3);
    chk("power_state", PWR_READY, power_state);
    u_host.wr(ADDR_FIRE, 8'h01);
    w(4);
    chk("fire_signal", 8'h01, fire_signal);
    chk("power_state", PWR_ACTIVE, power_state);
    chk("active_waveform", r, active_waveform);
    rd(ADDR_FIRE, 8'h01);
    w(6);
    chk("active_waveform", 8'h27, active_waveform);
    idle();
    rd(ADDR_FIRE, 8'h00);
    u_host.wr(ADDR_FIRE, 8'h01);
    w(4);
    u_host.wr(ADDR_FIRE, 8'h00);
    w(3);
    chk("drive_enable", 8'h00, drive_enable);
    u_host.wr(ADDR_FIRE, 8'h01);
    w(4);
    u_host.wr(ADDR_MODE, 8'h40);
    w(2);
    chk("drive_enable", 8'h00, drive_enable);
    chk("power_state", PWR_STANDBY, power_state);
    rd(ADDR_FIRE, 8'h00);
    u_host.pins(1'b0, 1'b0);
    w(2);
    chk("power_state", PWR_SHUTDOWN, power_state);
    u_host.wr(ADDR_RATED, r | 8'h80);
    u_host.rd(ADDR_RATED);
    u_host.pins(1'b1, 1'b0);
    rd(ADDR_RATED, RATED_RESET_VAL);
    rd(ADDR_SEQ_FIRST, r);
    u_host.wr(ADDR_MODE, 8'h00);
    u_host.wr(ADDR_RATED, r & 8'h7F);
    w(2);
    chk("drive_level", r & 8'h7F, drive_level);
    u_host.wr(ADDR_LOOP_CTRL, 8'h01);
    w(2);
    chk("drive_level", PEAK_RESET_VAL, drive_level);
    u_host.wr(ADDR_LOOP_CTRL, 8'h00);
    u_host.wr(ADDR_PEAK, 8'h9C);
    for (int m = 6; m < 8; m++) begin
      u_host.wr(ADDR_MODE, 8'(m));
      u_host.wr(ADDR_FIRE, 8'h01);
      w(3);
      chk("drive_enable", 8'h01, drive_enable);
      idle();
    end
    u_host.wr(ADDR_MODE, 8'h01);
    u_host.pins(1'b1, 1'b1);
    rd(ADDR_FIRE, 8'h01);
    u_host.pins(1'b1, 1'b0);
    rd(ADDR_FIRE, 8'h01);
    u_host.pins(1'b1, 1'b1);
    w(3);
    rd(ADDR_FIRE, 8'h00);
    u_host.wr(ADDR_MODE, 8'h02);
    w(2);
    rd(ADDR_FIRE, 8'h01);
    u_host.pins(1'b1, 1'b0);
    w(2);
    rd(ADDR_FIRE, 8'h00);
    w(0);
    chk("drive_enable", 8'h00, drive_enable);
    for (int m = 3; m < 6; m++) begin
      u_host.wr(ADDR_MODE, 8'(m));
      w(3);
      chk("fire_signal", 8'h01, fire_signal);
      rd(ADDR_FIRE, 8'h00);
    end
    u_host.wr(ADDR_MODE, 8'h00);
    u_host.wr(ADDR_FIRE, 8'h01);
    w(4);
    @(posedge ref_clk) output_short_sense <= 1'b1;
    w(2);
    chk("oc_flag", 8'h01, output_overcurrent_flag);
    chk("drive_enable", 8'h00, drive_enable);
    @(posedge ref_clk) output_short_sense <= 1'b0;
    w(2);
    chk("oc_flag", 8'h00, output_overcurrent_flag);
    @(posedge ref_clk) output_short_sense <= 1'b1;
    w(5);
    chk("oc_flag", 8'h00, output_overcurrent_flag);
    u_host.wr(ADDR_FIRE, 8'h01);
    w(4);
    chk("oc_flag", 8'h01, output_overcurrent_flag);
    @(posedge ref_clk) output_short_sense <= 1'b0;
    w(2);
    u_host.wr(ADDR_FIRE, 8'h01);
    w(4);
    chk("drive_enable", 8'h00, drive_enable);
    u_host.wr(ADDR_FIRE, 8'h00);
    u_host.wr(ADDR_MODE, 8'h01);
    u_host.wr(ADDR_MODE, 8'h00);
    u_host.wr(ADDR_FIRE, 8'h01);
    w(4);
    chk("drive_enable", 8'h01, drive_enable);
    u_host.wr(ADDR_MODE, 8'h80);
    w(2);
    chk("drive_enable", 8'h00, drive_enable);
    rd(ADDR_MODE, MODE_RESET_VAL);
    rd(ADDR_RATED, RATED_RESET_VAL);
    u_host.wr(ADDR_SEQ_FIRST, r);
    @(posedge ref_clk) regulator_short_pin <= 1'b1;
    w(2);
    chk("power_state", PWR_SHUTDOWN, power_state);
    @(posedge ref_clk) regulator_short_pin <= 1'b0;
    w(2);
    rd(ADDR_SEQ_FIRST, SEQ_RESET_VAL);
    w(4);
    chk("pending_reads", 8'h00, 8'(exp_q.size()));
    test_done();
  end
endmodule : tb_top
